/* logic/lfs_fault_latch.sv */
// Holding latch for one group of per-channel fault results
module lfs_fault_latch import lfs_pkg::*; #(
    parameter int W = CH_N
) (
    input  logic         clk,
    input  logic         reset,
    input  logic         capture,
    input  logic [W-1:0] cmp,
    input  logic [W-1:0] qualify,
    output logic [W-1:0] result
);
    logic [W-1:0] next_result;

    // Unqualified channels load zero at each capture
    always_comb begin
        next_result = result;
        if (capture) begin
            next_result = cmp & qualify;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            result <= '0;
        end else begin
            result <= next_result;
        end
    end
endmodule

/* logic/lfs_pkg.sv */
// Package: constants, types and status snapshot packer for LED fault capture
package lfs_pkg;
    localparam int CH_N     = 16;
    localparam int SR_W     = 257;
    localparam int SR_MSB   = 256;
    localparam int WORD_W   = 256;
    localparam int CNT_W    = 8;
    localparam int OPEN_HI  = 240;
    localparam int OPEN_LO  = 224;
    localparam int SHORT_HI = 208;
    localparam int SHORT_LO = 192;
    localparam int LEAK_HI  = 176;
    localparam int LEAK_LO  = 160;
    localparam int TEF_POS  = 151;
    localparam int PTW_POS  = 150;
    localparam int ISF_POS  = 149;
    localparam logic [CNT_W-1:0] LATCH_CNT_0 = 8'h02;
    localparam logic [CNT_W-1:0] LATCH_CNT_1 = 8'h04;
    localparam logic [CNT_W-1:0] LATCH_CNT_2 = 8'h08;
    localparam logic [CNT_W-1:0] LATCH_CNT_3 = 8'h10;

    typedef struct packed {
        logic [CH_N-1:0] open_fault;
        logic [CH_N-1:0] short_fault;
        logic [CH_N-1:0] leak_fault;
        logic            overtemp_error_flag;
        logic            heat_warning_flag;
        logic            ref_pin_ground_flag;
    } lfs_faults_t;

    typedef enum logic [1:0] {
        SID_ARMED = 2'b01,
        SID_HELD  = 2'b10
    } lfs_sid_t;

    typedef struct packed {
        logic [SR_W-1:0]   sr;
        logic [WORD_W-1:0] word;
        lfs_sid_t          status_snapshot;
        logic              sclk_d;
        logic              lat_d;
        logic              gclk_d;
        logic              blank_d;
        logic [CNT_W-1:0]  gcnt;
        logic              gs_write;
        logic              ctl_write;
        logic [CH_N-1:0]   leak_src;
        logic [1:0]        open_sel;
        logic [1:0]        short_sel;
    } lfs_top_st_t;

    // Places every fault bit; untouched positions stay zero
    function automatic logic [SR_W-1:0] lfs_pack(lfs_faults_t f);
        logic [SR_W-1:0] v;
        v = '0;
        v[OPEN_HI +: 8]  = f.open_fault[15:8];
        v[OPEN_LO +: 8]  = f.open_fault[7:0];
        v[SHORT_HI +: 8] = f.short_fault[15:8];
        v[SHORT_LO +: 8] = f.short_fault[7:0];
        v[LEAK_HI +: 8]  = f.leak_fault[15:8];
        v[LEAK_LO +: 8]  = f.leak_fault[7:0];
        v[TEF_POS]       = f.overtemp_error_flag;
        v[PTW_POS]       = f.heat_warning_flag;
        v[ISF_POS]       = f.ref_pin_ground_flag;
        return v;
    endfunction
endpackage

/* logic/lfs_sync.sv */
// Two-flop synchroniser for pins from outside the MCLK domain
module lfs_sync import lfs_pkg::*; #(
    parameter int W = 1
) (
    input  logic         clk,
    input  logic         reset,
    input  logic [W-1:0] d,
    output logic [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } lfs_sync_st_t;

    lfs_sync_st_t st;
    lfs_sync_st_t next_st;

    // First stage feeds only the second stage
    always_comb begin
        next_st.s1 = d;
        next_st.s2 = st.s1;
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign q = st.s2;
endmodule

/* logic/lfs_top.sv */
// LED fault latching and status snapshot shift register
module lfs_top import lfs_pkg::*; #(
    parameter logic [CNT_W-1:0] LAT_CNT_0 = LATCH_CNT_0,
    parameter logic [CNT_W-1:0] LAT_CNT_1 = LATCH_CNT_1,
    parameter logic [CNT_W-1:0] LAT_CNT_2 = LATCH_CNT_2,
    parameter logic [CNT_W-1:0] LAT_CNT_3 = LATCH_CNT_3
) (
    input  logic              MCLK,
    input  logic              RESET,
    input  logic              SHIFT_CLK,
    input  logic              SERIAL_IN,
    input  logic              LATCH_STROBE,
    input  logic              GRAYSCALE_CLK,
    input  logic              DISPLAY_START,
    input  logic              DISPLAY_END,
    input  logic              BLANK,
    input  logic              DISPLAY_TIMING_RESET,
    input  logic [1:0]        FAULT_LATCH_TIMING,
    input  logic [1:0]        OPEN_THRESHOLD_CFG,
    input  logic [1:0]        SHORT_THRESHOLD_CFG,
    input  logic              LEAK_CHECK_ENABLE,
    input  logic              INVISIBLE_CHECK_MODE,
    input  logic [CH_N-1:0]   OUTPUT_ON,
    input  logic [CH_N-1:0]   GRAYSCALE_ZERO,
    input  logic [CH_N-1:0]   OPEN_CMP,
    input  logic [CH_N-1:0]   SHORT_CMP,
    input  logic [CH_N-1:0]   LEAK_CMP,
    input  logic              OVERTEMP_IN,
    input  logic              HEAT_WARN_IN,
    input  logic              REF_SHORT_IN,
    output logic              SERIAL_OUT,
    output logic [WORD_W-1:0] LATCHED_WORD,
    output logic              GS_WRITE,
    output logic              CONTROL_WRITE,
    output logic [CH_N-1:0]   LEAK_SOURCE_EN,
    output logic [1:0]        OPEN_THRESHOLD_SEL,
    output logic [1:0]        SHORT_THRESHOLD_SEL
);
    localparam int SYNC_W = 4 + 3 * CH_N + 3;
    localparam logic [SR_W-1:0] USED_MASK = lfs_pack('1);

    // A zero count wraps to 255 and would match every edge once the count saturates
    if (LAT_CNT_0 == '0 || LAT_CNT_1 == '0 || LAT_CNT_2 == '0 || LAT_CNT_3 == '0) begin : g_chk
        $error("lfs_top: latch counts must be nonzero");
    end

    lfs_top_st_t st;
    lfs_top_st_t next_st;

    logic [SYNC_W-1:0] sync_q;
    logic              s_sclk;
    logic              s_sin;
    logic              s_lat;
    logic              s_gclk;
    logic [CH_N-1:0]   s_open;
    logic [CH_N-1:0]   s_short;
    logic [CH_N-1:0]   s_leak;
    logic              s_tef;
    logic              s_ptw;
    logic              s_isf;

    // Link pins, grayscale clock, comparators and flags are asynchronous to MCLK
    lfs_sync #(.W(SYNC_W)) u_sync (
        .clk   (MCLK),
        .reset (RESET),
        .d     ({SHIFT_CLK, SERIAL_IN, LATCH_STROBE, GRAYSCALE_CLK,
                 OPEN_CMP, SHORT_CMP, LEAK_CMP,
                 OVERTEMP_IN, HEAT_WARN_IN, REF_SHORT_IN}),
        .q     (sync_q)
    );

    assign {s_sclk, s_sin, s_lat, s_gclk, s_open, s_short, s_leak, s_tef, s_ptw, s_isf} = sync_q;

    logic            sclk_rise;
    logic            lat_rise;
    logic            gclk_rise;
    logic            blank_rise;
    logic            gs_load;
    logic            fault_cap;
    logic            leak_cap;
    logic            leak_en;
    logic [CNT_W-1:0] target;
    logic [CH_N-1:0] open_qual;
    logic [CH_N-1:0] leak_qual;
    logic [CH_N-1:0] open_res;
    logic [CH_N-1:0] short_res;
    logic [CH_N-1:0] leak_res;
    lfs_faults_t     faults;

    // Edges of the sampled link pins and grayscale clock, and of unsynchronised BLANK
    assign sclk_rise  = s_sclk & ~st.sclk_d;
    assign lat_rise   = s_lat & ~st.lat_d;
    assign gclk_rise  = s_gclk & ~st.gclk_d;
    assign blank_rise = BLANK & ~st.blank_d;

    // Snapshot load only when top bit clear and armed by reset or by a shift since the last load
    assign gs_load = lat_rise & ~st.sr[SR_MSB] & (st.status_snapshot == SID_ARMED);

    // Latch moment: grayscale clock count reaches the selected figure
    always_comb begin
        case (FAULT_LATCH_TIMING)
            2'b00:   target = LAT_CNT_0;
            2'b01:   target = LAT_CNT_1;
            2'b10:   target = LAT_CNT_2;
            default: target = LAT_CNT_3;
        endcase
    end

    assign fault_cap = gclk_rise & ~DISPLAY_START & (st.gcnt == target - 8'h01);

    // Invisible mode lets off outputs report open and short results
    assign open_qual = OUTPUT_ON | {CH_N{INVISIBLE_CHECK_MODE}};

    // Leak check needs enable and no invisible mode
    assign leak_en   = LEAK_CHECK_ENABLE & ~INVISIBLE_CHECK_MODE;
    assign leak_qual = ~OUTPUT_ON & GRAYSCALE_ZERO & {CH_N{leak_en}};

    // Leak latch at period end, blank rising, and optionally on write
    assign leak_cap = DISPLAY_END | blank_rise | (DISPLAY_TIMING_RESET & gs_load);

    // Open comparator high means output below open threshold
    lfs_fault_latch #(.W(CH_N)) u_open (
        .clk     (MCLK),
        .reset   (RESET),
        .capture (fault_cap),
        .cmp     (s_open),
        .qualify (open_qual),
        .result  (open_res)
    );

    // Short comparator high means output above short threshold
    lfs_fault_latch #(.W(CH_N)) u_short (
        .clk     (MCLK),
        .reset   (RESET),
        .capture (fault_cap),
        .cmp     (s_short),
        .qualify (open_qual),
        .result  (short_res)
    );

    // Leak comparator: test-current output below short threshold
    lfs_fault_latch #(.W(CH_N)) u_leak (
        .clk     (MCLK),
        .reset   (RESET),
        .capture (leak_cap),
        .cmp     (s_leak),
        .qualify (leak_qual),
        .result  (leak_res)
    );

    // Flags are live levels taken at the load moment
    always_comb begin
        faults.open_fault          = open_res;
        faults.short_fault         = short_res;
        faults.leak_fault          = leak_res;
        faults.overtemp_error_flag = s_tef;
        faults.heat_warning_flag   = s_ptw;
        faults.ref_pin_ground_flag = s_isf;
    end

    // Next-state logic for the whole block
    always_comb begin
        next_st           = st;
        next_st.sclk_d    = s_sclk;
        next_st.lat_d     = s_lat;
        next_st.gclk_d    = s_gclk;
        next_st.blank_d   = BLANK;
        next_st.gs_write  = 1'b0;
        next_st.ctl_write = 1'b0;
        next_st.open_sel  = OPEN_THRESHOLD_CFG;
        next_st.short_sel = SHORT_THRESHOLD_CFG;
        next_st.leak_src  = leak_en ? ~OUTPUT_ON : '0;
        // Count saturates so a slow period never wraps into a false match
        if (DISPLAY_START) begin
            next_st.gcnt = '0;
        end else if (gclk_rise && st.gcnt != '1) begin
            next_st.gcnt = st.gcnt + 8'h01;
        end
        // Strobe wins over a coincident shift edge
        if (lat_rise) begin
            if (st.sr[SR_MSB]) begin
                next_st.ctl_write = 1'b1;
                next_st.word      = st.sr[WORD_W-1:0];
            end else if (st.status_snapshot == SID_ARMED) begin
                next_st.gs_write = 1'b1;
                next_st.word     = st.sr[WORD_W-1:0];
                next_st.sr       = lfs_pack(faults);
                next_st.status_snapshot      = SID_HELD;
            end
        end else if (sclk_rise) begin
            next_st.sr  = {st.sr[SR_MSB-1:0], s_sin};
            next_st.status_snapshot = SID_ARMED;
        end
        case (next_st.status_snapshot)
            SID_ARMED: next_st.status_snapshot = next_st.status_snapshot;
            SID_HELD:  next_st.status_snapshot = next_st.status_snapshot;
            default:   next_st.status_snapshot = SID_ARMED;
        endcase
    end

    always_ff @(posedge MCLK) begin
        if (RESET) begin
            st     <= '0;
            st.status_snapshot <= SID_ARMED;
        end else begin
            st <= next_st;
        end
    end

    // All outputs straight from flip-flops
    assign SERIAL_OUT          = st.sr[SR_MSB];
    assign LATCHED_WORD        = st.word;
    assign GS_WRITE            = st.gs_write;
    assign CONTROL_WRITE       = st.ctl_write;
    assign LEAK_SOURCE_EN      = st.leak_src;
    assign OPEN_THRESHOLD_SEL  = st.open_sel;
    assign SHORT_THRESHOLD_SEL = st.short_sel;

    // Checks on snapshot layout, latching and shifting
    default clocking cb @(posedge MCLK);
    endclocking
    default disable iff (RESET);

    sequence s_load;
        gs_load;
    endsequence

    sequence s_held_strobe;
        lat_rise && (st.status_snapshot == SID_HELD) && !st.sr[SR_MSB];
    endsequence

    short_hi_map_a: assert property (s_load |=> st.sr[SHORT_HI +: 8] == $past(short_res[15:8]))
        else $error("short faults 8-15 misplaced");
    short_lo_map_a: assert property (s_load |=> st.sr[SHORT_LO +: 8] == $past(short_res[7:0]))
        else $error("short faults 0-7 misplaced");
    leak_map_a: assert property (s_load |=> {st.sr[LEAK_HI +: 8], st.sr[LEAK_LO +: 8]} == $past(leak_res))
        else $error("leak faults misplaced");
    flag_map_a: assert property (s_load |=> {st.sr[TEF_POS], st.sr[PTW_POS], st.sr[ISF_POS]}
                                            == $past({s_tef, s_ptw, s_isf}))
        else $error("thermal or reference flags misplaced");
    open_map_a: assert property (s_load |=> {st.sr[OPEN_HI +: 8], st.sr[OPEN_LO +: 8]} == $past(open_res))
        else $error("open faults misplaced");
    reserved_zero_a: assert property (s_load |=> (st.sr & ~USED_MASK) == '0 && GS_WRITE)
        else $error("reserved snapshot bits not zero");
    open_capture_a: assert property (fault_cap |=> open_res == $past(s_open & open_qual))
        else $error("open result not latched at latch moment");
    short_capture_a: assert property (fault_cap |=> short_res == $past(s_short & open_qual))
        else $error("short result not latched at latch moment");
    leak_capture_a: assert property (leak_cap |=> leak_res == $past(s_leak & leak_qual))
        else $error("leak result not latched on leak event");
    leak_off_a: assert property (leak_cap && !leak_en |=> leak_res == '0 && LEAK_SOURCE_EN == '0)
        else $error("leak check active while disabled");
    msb_skip_a: assert property (lat_rise && st.sr[SR_MSB] |=> CONTROL_WRITE && !GS_WRITE
                                 && st.sr == $past(st.sr))
        else $error("control write overwrote shift register");
    reload_block_a: assert property (s_held_strobe |=> !GS_WRITE && st.sr == $past(st.sr))
        else $error("snapshot reloaded without new shift bit");
    shift_out_a: assert property (sclk_rise && !lat_rise |=> st.sr[0] == $past(s_sin)
                                  && SERIAL_OUT == $past(st.sr[SR_MSB-1]))
        else $error("shift step wrong");

    // Pulses, copies and holds; every output is a flop,
    // so each consequent looks one cycle after its cause

    sequence s_ctl_strobe;
        lat_rise && st.sr[SR_MSB];
    endsequence

    sequence s_shift_only;
        sclk_rise && !lat_rise;
    endsequence

    // Write and control pulses last exactly one cycle
    write_pulse_a: assert property (s_load |=> GS_WRITE ##1 !GS_WRITE)
        else $error("write pulse not one cycle");

    ctl_pulse_a: assert property (s_ctl_strobe |=> CONTROL_WRITE ##1 !CONTROL_WRITE)
        else $error("control pulse not one cycle");

    // Old shift content reaches the word in the same cycle the snapshot replaces it
    word_copy_a: assert property (s_load |=> LATCHED_WORD == $past(st.sr[WORD_W-1:0]))
        else $error("latched word not copied on write");

    ctl_word_a: assert property (s_ctl_strobe |=> LATCHED_WORD == $past(st.sr[WORD_W-1:0]))
        else $error("control word not copied");

    snap_top_zero_a: assert property (s_load |=> !SERIAL_OUT)
        else $error("snapshot top bit not zero");

    // Arm and hold steps of the reload guard
    shift_arms_a: assert property (s_shift_only |=> st.status_snapshot == SID_ARMED)
        else $error("shift did not arm snapshot");

    load_holds_a: assert property (s_load |=> st.status_snapshot == SID_HELD)
        else $error("snapshot not held after load");

    no_edge_hold_a: assert property (!sclk_rise && !lat_rise |=> st.sr == $past(st.sr))
        else $error("shift register moved without edge");

    // Results only move at their own capture moments
    open_hold_a: assert property (!fault_cap |=> open_res == $past(open_res))
        else $error("open result moved outside latch moment");

    short_hold_a: assert property (!fault_cap |=> short_res == $past(short_res))
        else $error("short result moved outside latch moment");

    leak_hold_a: assert property (!leak_cap |=> leak_res == $past(leak_res))
        else $error("leak result moved outside leak event");

    // Off outputs read open and short zero unless invisible mode is on; leak reads zero where grayscale is nonzero
    open_zero_off_a: assert property (fault_cap && !INVISIBLE_CHECK_MODE
                                      |=> (open_res & ~$past(OUTPUT_ON)) == '0)
        else $error("open fault reported for off output");

    short_zero_off_a: assert property (fault_cap && !INVISIBLE_CHECK_MODE
                                       |=> (short_res & ~$past(OUTPUT_ON)) == '0)
        else $error("short fault reported for off output");

    leak_gs_zero_a: assert property (leak_cap |=> (leak_res & ~$past(GRAYSCALE_ZERO)) == '0)
        else $error("leak fault reported for nonzero grayscale");

    // Test current follows the off outputs only while checking is on
    leak_src_a: assert property (leak_en |=> LEAK_SOURCE_EN == $past(~OUTPUT_ON))
        else $error("leak source not on off outputs");

    leak_src_off_a: assert property (!leak_en |=> LEAK_SOURCE_EN == '0)
        else $error("leak source on while check disabled");

    // Period start restarts the latch moment count
    gcnt_clear_a: assert property (DISPLAY_START |=> st.gcnt == '0)
        else $error("grayscale count not cleared");

    thresh_copy_a: assert property (1'b1 |=> {OPEN_THRESHOLD_SEL, SHORT_THRESHOLD_SEL}
                                    == $past({OPEN_THRESHOLD_CFG, SHORT_THRESHOLD_CFG}))
        else $error("threshold fields not passed through");
endmodule

/* verification/lfs_ctl_model.sv */
// Serial display controller model driving the link pins
module lfs_ctl_model import lfs_pkg::*; (
    output logic      SHIFT_CLK,
    output logic      SERIAL_IN,
    output logic      LATCH_STROBE,
    input  wire logic SERIAL_OUT
);
    timeunit 1ns;
    timeprecision 100ps;

    // Link pins idle low from time zero
    initial begin
        SHIFT_CLK = 1'b0;
        SERIAL_IN = 1'b0;
        LATCH_STROBE = 1'b0;
    end

    // Strobe pulse at the 125 ns link rate
    task automatic strobe();
        #62 LATCH_STROBE = 1'b1;
        #63 LATCH_STROBE = 1'b0;
        #63;
    endtask

    // Shifts a word top bit first, reading the old content as it leaves
    task automatic xfer(input logic [SR_W-1:0] w, input bit lat, output logic [SR_W-1:0] seen);
        int n;
        n = lat ? SR_W : WORD_W;
        seen = '0;
        seen[SR_MSB] = SERIAL_OUT;
        for (int k = 1; k <= n; k++) begin
            SERIAL_IN = w[SR_W-k];
            #62 SHIFT_CLK = 1'b1;
            #63 SHIFT_CLK = 1'b0;
            if (k <= WORD_W) seen[SR_W-1-k] = SERIAL_OUT;
        end
        // Released data line must not keep its last value
        SERIAL_IN = ~SERIAL_IN;
        if (lat) strobe();
    endtask
endmodule

/* verification/lfs_top_test.sv */
// Self-checking bench for the LED fault capture block
module lfs_top_test import lfs_pkg::*; ;
    timeunit 1ns;
    timeprecision 100ps;
    logic              MCLK, RESET, GRAYSCALE_CLK, DISPLAY_START, DISPLAY_END, BLANK;
    logic              DISPLAY_TIMING_RESET, LEAK_CHECK_ENABLE, INVISIBLE_CHECK_MODE;
    logic              OVERTEMP_IN, HEAT_WARN_IN, REF_SHORT_IN;
    logic              SHIFT_CLK, SERIAL_IN, LATCH_STROBE, SERIAL_OUT, GS_WRITE, CONTROL_WRITE;
    logic [1:0]        FAULT_LATCH_TIMING, OPEN_THRESHOLD_CFG, SHORT_THRESHOLD_CFG;
    logic [1:0]        OPEN_THRESHOLD_SEL, SHORT_THRESHOLD_SEL;
    logic [CH_N-1:0]   OUTPUT_ON, GRAYSCALE_ZERO, OPEN_CMP, SHORT_CMP, LEAK_CMP, LEAK_SOURCE_EN;
    logic [WORD_W-1:0] LATCHED_WORD;
    logic [CH_N-1:0]   exp_open, exp_short, exp_leak;
    logic [SR_W-1:0]   seen;
    int                num_errors = 0, tests_run = 0, gs_cnt = 0, ctl_cnt = 0;

    lfs_top dut_u (.MCLK(MCLK), .RESET(RESET), .SHIFT_CLK(SHIFT_CLK), .SERIAL_IN(SERIAL_IN),
        .LATCH_STROBE(LATCH_STROBE), .GRAYSCALE_CLK(GRAYSCALE_CLK), .DISPLAY_START(DISPLAY_START),
        .DISPLAY_END(DISPLAY_END), .BLANK(BLANK), .DISPLAY_TIMING_RESET(DISPLAY_TIMING_RESET),
        .FAULT_LATCH_TIMING(FAULT_LATCH_TIMING), .OPEN_THRESHOLD_CFG(OPEN_THRESHOLD_CFG),
        .SHORT_THRESHOLD_CFG(SHORT_THRESHOLD_CFG), .LEAK_CHECK_ENABLE(LEAK_CHECK_ENABLE),
        .INVISIBLE_CHECK_MODE(INVISIBLE_CHECK_MODE), .OUTPUT_ON(OUTPUT_ON),
        .GRAYSCALE_ZERO(GRAYSCALE_ZERO), .OPEN_CMP(OPEN_CMP), .SHORT_CMP(SHORT_CMP),
        .LEAK_CMP(LEAK_CMP), .OVERTEMP_IN(OVERTEMP_IN), .HEAT_WARN_IN(HEAT_WARN_IN),
        .REF_SHORT_IN(REF_SHORT_IN), .SERIAL_OUT(SERIAL_OUT), .LATCHED_WORD(LATCHED_WORD),
        .GS_WRITE(GS_WRITE), .CONTROL_WRITE(CONTROL_WRITE), .LEAK_SOURCE_EN(LEAK_SOURCE_EN),
        .OPEN_THRESHOLD_SEL(OPEN_THRESHOLD_SEL), .SHORT_THRESHOLD_SEL(SHORT_THRESHOLD_SEL));

    lfs_ctl_model ctl_u (.SHIFT_CLK(SHIFT_CLK), .SERIAL_IN(SERIAL_IN), .LATCH_STROBE(LATCH_STROBE),
        .SERIAL_OUT(SERIAL_OUT));

    // 125 MHz system clock
    initial begin
        MCLK = 1'b0;
        forever #4 MCLK = ~MCLK;
    end

    // Pulse counters; the one-cycle pulses are easy to miss otherwise
    always @(posedge MCLK) begin
        if (GS_WRITE === 1'b1) gs_cnt++;
        if (CONTROL_WRITE === 1'b1) ctl_cnt++;
    end

    task automatic tick(int n);
        repeat (n) @(posedge MCLK);
        #1;
    endtask

    task automatic check(string name, logic [SR_W-1:0] s, logic [SR_W-1:0] e);
        tests_run++;
        if (s !== e) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", name, e, s);
        end
    endtask

    // Expected snapshot built bit by bit, independent of the packer
    function automatic logic [SR_W-1:0] exp_snap();
        logic [SR_W-1:0] v;
        v = '0;
        v[247:240] = exp_open[15:8];
        v[231:224] = exp_open[7:0];
        v[215:208] = exp_short[15:8];
        v[199:192] = exp_short[7:0];
        v[183:176] = exp_leak[15:8];
        v[167:160] = exp_leak[7:0];
        v[151] = OVERTEMP_IN;
        v[150] = HEAT_WARN_IN;
        v[149] = REF_SHORT_IN;
        return v;
    endfunction

    // Load a snapshot with a write, then clock it out without a strobe
    task automatic snap(string name);
        logic [SR_W-1:0] w;
        int              g;
        w = {1'b0, {8{32'h6c3a_95e1}}};
        g = gs_cnt;
        ctl_u.xfer(w, 1'b1, seen);
        tick(2);
        check("latched word", LATCHED_WORD, w[WORD_W-1:0]);
        check("write pulse", SR_W'(gs_cnt), SR_W'(g + 1));
        ctl_u.xfer(w, 1'b0, seen);
        check(name, seen, exp_snap());
        $display("test %s done", name);
    endtask

    task automatic gs_edges(int n);
        repeat (n) begin
            GRAYSCALE_CLK = 1'b1;
            tick(4);
            GRAYSCALE_CLK = 1'b0;
            tick(4);
        end
    endtask

    task automatic test_reset();
        check("reset outputs", {SERIAL_OUT, GS_WRITE, CONTROL_WRITE, LEAK_SOURCE_EN}, '0);
        check("reset word", LATCHED_WORD, '0);
        OPEN_THRESHOLD_CFG = 2'b10;
        SHORT_THRESHOLD_CFG = 2'b01;
        tick(2);
        check("thresholds", {OPEN_THRESHOLD_SEL, SHORT_THRESHOLD_SEL}, 4'h9);
        $display("test reset done");
    endtask

    // Comparators differ before, at and after the chosen edge
    task automatic test_latch(logic [1:0] t);
        logic [CH_N-1:0] b;
        logic [CH_N-1:0] q;
        b = 16'hc3a5 ^ (16'h1111 << t);
        FAULT_LATCH_TIMING = t;
        INVISIBLE_CHECK_MODE = t[0];
        {OVERTEMP_IN, HEAT_WARN_IN, REF_SHORT_IN} = {t, ~t[0]};
        OPEN_CMP = ~b;
        SHORT_CMP = b;
        tick(6);
        DISPLAY_START = 1'b1;
        tick(1);
        DISPLAY_START = 1'b0;
        gs_edges((2 << t) - 1);
        OPEN_CMP = b;
        SHORT_CMP = ~b;
        tick(6);
        gs_edges(1);
        OPEN_CMP = ~b;
        SHORT_CMP = b;
        gs_edges(3);
        q = OUTPUT_ON | {CH_N{t[0]}};
        exp_open = b & q;
        exp_short = ~b & q;
        snap("latch timing");
    endtask

    task automatic test_leak();
        LEAK_CHECK_ENABLE = 1'b1;
        INVISIBLE_CHECK_MODE = 1'b0;
        LEAK_CMP = 16'hffff;
        tick(6);
        check("leak source", LEAK_SOURCE_EN, {~OUTPUT_ON});
        DISPLAY_END = 1'b1;
        tick(1);
        DISPLAY_END = 1'b0;
        LEAK_CMP = 16'h0000;
        exp_leak = ~OUTPUT_ON & GRAYSCALE_ZERO;
        snap("leak period end");
        LEAK_CHECK_ENABLE = 1'b0;
        LEAK_CMP = 16'hffff;
        tick(6);
        check("leak source off", LEAK_SOURCE_EN, '0);
        BLANK = 1'b1;
        tick(4);
        BLANK = 1'b0;
        exp_leak = '0;
        snap("leak on blank");
        LEAK_CHECK_ENABLE = 1'b1;
        DISPLAY_TIMING_RESET = 1'b1;
        tick(6);
        snap("leak before write capture");
        DISPLAY_TIMING_RESET = 1'b0;
        exp_leak = ~OUTPUT_ON & GRAYSCALE_ZERO;
        snap("leak after write capture");
        INVISIBLE_CHECK_MODE = 1'b1;
        tick(6);
        check("leak source idm", LEAK_SOURCE_EN, '0);
        INVISIBLE_CHECK_MODE = 1'b0;
    endtask

    // Second strobe without shifting is ignored; top bit set skips the load
    task automatic test_refuse();
        int g;
        int c;
        ctl_u.xfer({1'b0, {8{32'h0f1e_2d3c}}}, 1'b1, seen);
        tick(2);
        g = gs_cnt;
        c = ctl_cnt;
        ctl_u.strobe();
        tick(2);
        check("refused write", SR_W'(gs_cnt), SR_W'(g));
        ctl_u.xfer({1'b1, {WORD_W{1'b0}}}, 1'b1, seen);
        tick(2);
        check("control pulse", SR_W'(ctl_cnt), SR_W'(c + 1));
        check("no snapshot", SR_W'(gs_cnt), SR_W'(g));
        check("top bit kept", {SERIAL_OUT}, 1'b1);
        $display("test refuse done");
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // Main sequence; link pins stay low through reset
    initial begin
        RESET = 1'b1;
        {GRAYSCALE_CLK, DISPLAY_START, DISPLAY_END, BLANK, DISPLAY_TIMING_RESET} = '0;
        {LEAK_CHECK_ENABLE, INVISIBLE_CHECK_MODE, OVERTEMP_IN, HEAT_WARN_IN, REF_SHORT_IN} = '0;
        {FAULT_LATCH_TIMING, OPEN_THRESHOLD_CFG, SHORT_THRESHOLD_CFG} = '0;
        {OPEN_CMP, SHORT_CMP, LEAK_CMP} = '0;
        OUTPUT_ON = 16'h3cf0;
        GRAYSCALE_ZERO = 16'hf00f;
        {exp_open, exp_short, exp_leak} = '0;
        tick(10);
        RESET = 1'b0;
        tick(1);
        test_reset();
        for (int t = 0; t < 4; t++) test_latch(2'(t));
        test_leak();
        test_refuse();
        stop_test();
    end

    // About 73k cycles expected; 1 ms leaves ample margin
    initial begin
        #1_000_000;
        num_errors++;
        stop_test();
    end
endmodule
